/* File: cslrq_map.vh */
// Constants for the lamp and diagnostic-interrupt block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef CSLRQ_MAP_VH
`define CSLRQ_MAP_VH

`define CSLRQ_CLK_HZ          50000000
// Activity timeout 0.5 s, written as 500 ms
`define CSLRQ_ACT_MS          500
`define CSLRQ_ACT_CYC         ((`CSLRQ_CLK_HZ / 1000) * `CSLRQ_ACT_MS)
// Channel lamp toggle limit 12 Hz: least half period between toggles
`define CSLRQ_LIM_HZ          12
`define CSLRQ_LIM_CYC         (`CSLRQ_CLK_HZ / (2 * `CSLRQ_LIM_HZ))
// Fault lamp flash rate (half period), about 2 Hz
`define CSLRQ_FLASH_HZ        2
`define CSLRQ_FLASH_CYC       (`CSLRQ_CLK_HZ / (2 * `CSLRQ_FLASH_HZ))

// Diagnostic vector bit positions
`define CSLRQ_D_PARAM         0
`define CSLRQ_D_HWLOST        1
`define CSLRQ_D_UNAVAIL       2
`define CSLRQ_D_INTERNAL      3
`define CSLRQ_D_WDOG          4
`define CSLRQ_D_WIREBRK       5
`define CSLRQ_D_GENERAL       6
`define CSLRQ_D_LOADMISS      7
`define CSLRQ_D_ENCSHORT      8
`define CSLRQ_D_OUTFAULT      9
`define CSLRQ_D_SUPPLY        10
`define CSLRQ_D_TRACK         11
`define CSLRQ_D_OVERTEMP      12
`define CSLRQ_D_W             13
`define CSLRQ_D_ZERO          13'h0000

// Register offsets
`define CSLRQ_A_CTRL          4'h0
`define CSLRQ_A_STAT          4'h1
`define CSLRQ_A_MASK          4'h2
`define CSLRQ_A_PEND          4'h3
// Control bit positions
`define CSLRQ_C_PARAM_OK      0
`define CSLRQ_C_PUSHPULL      1
`define CSLRQ_C_WB_EN         2
`define CSLRQ_C_ADD_EN        3
`define CSLRQ_C_FAST          4
`define CSLRQ_C_MOTION        5
`define CSLRQ_C_NEWREV        6
`define CSLRQ_CTRL_RST        7'h00
`define CSLRQ_MASK_RST        13'h0000

`endif

/* File: cslrq_lamp_lim.v */
// One channel lamp with toggle-rate limiter.
// Assumes a synchronous signal level on i_sig.
`timescale 1ns/1ps
`include "cslrq_map.vh"

module cslrq_lamp_lim (
   // Clock and reset
   input  wire i_core_clk,
   input  wire i_rst,
   // Signal level
   input  wire i_sig,
   // Lamp
   output reg  o_lamp
);
   localparam integer LIM_I = `CSLRQ_LIM_CYC;
   localparam [20:0]  LIM   = LIM_I[20:0];
   reg [20:0] hold_r;

   // Lamp may only change once the hold time has run out; a fast signal
   // thus blinks at the limit rate instead of tracking.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_lamp <= 1'b0;
         hold_r <= 21'h00_0000;
      end else if (hold_r != 21'h00_0000) begin
         hold_r <= hold_r - 21'h00_0001;
      end else if (o_lamp != i_sig) begin
         o_lamp <= i_sig;
         hold_r <= LIM - 21'h00_0001;
      end
   end
endmodule // cslrq_lamp_lim

/* File: cslrq_top.v */
// Lamp drive and diagnostic-interrupt logic of a one-channel counter.
// Assumes synchronous inputs; software port with read data one cycle late.
// How it works
// - Fault lamp dark without backplane supply
// - Fault lamp flashes until parameters assigned
// - Fault lamp steady when assigned, no diagnostics
// - Diagnostics flash red; cleared errors give green
// - Supply lamps show supply and encoder faults
// - Channel lamps follow signal or output level
// - Channel lamps toggle at most about 12 Hz
// - Direction lamps off after 0.5 s idle
// - Up lamp after recent incrementing pulse
// - Down lamp after recent decrementing pulse
// - Fatal class diagnostics always latch; interrupt when unmasked
// - Wire break monitored for push-pull, enable gated
// - Additional diagnostics interrupt only when enabled
// - No lost-interrupt diagnostic in fast/motion modes
// - New revision folds supply error into load missing
// - Block keeps running after an interrupt
// - Lost interrupt when previous still unprocessed
// - Invalid track transition on too small phase
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "cslrq_map.vh"

module cslrq_top (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_rst,
   // Supply state
   input  wire        i_bus_supply_ok,
   input  wire        i_load_supply_ok,
   input  wire        i_enc_supply_fault,
   input  wire        i_undervoltage,
   // Channel signals
   input  wire        i_track_a,
   input  wire        i_track_b,
   input  wire        i_track_n,
   input  wire [2:0]  i_aux_input_m,
   input  wire [1:0]  i_out_cmd,
   // Count pulses
   input  wire        i_count_pulse,
   input  wire        i_count_up,
   // Fault detections
   input  wire        i_param_err,
   input  wire        i_hw_irq_req,
   input  wire        i_hw_irq_ack,
   input  wire        i_unavail,
   input  wire        i_internal_err,
   input  wire        i_wdog_trip,
   input  wire        i_wire_break,
   input  wire        i_general_err,
   input  wire        i_out_fault,
   input  wire        i_overtemp,
   input  wire        i_track_phase_short,
   // Register port
   input  wire [3:0]  i_addr,
   input  wire [15:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [15:0] o_rdata,
   // Lamps
   output reg         o_fault_lamp_red,
   output reg         o_fault_lamp_green,
   output reg         o_bus_power_lamp,
   output reg         o_load_supply_lamp,
   output wire        o_track_a_lamp,
   output wire        o_track_b_lamp,
   output wire        o_track_n_lamp,
   output wire [2:0]  o_aux_input_lamp,
   output wire [1:0]  o_out_lamp,
   output reg         o_count_up_lamp,
   output reg         o_count_down_lamp,
   // Interrupt
   output wire        o_irq
);
   // Counts fit their counters; slice on purpose from the integer form
   localparam integer ACT_I   = `CSLRQ_ACT_CYC;
   localparam integer FLASH_I = `CSLRQ_FLASH_CYC;
   localparam [24:0] ACT   = ACT_I[24:0];
   localparam [23:0] FLASH = FLASH_I[23:0];
   localparam [1:0]  FL_OFF = 2'b01;
   localparam [1:0]  FL_ON  = 2'b10;

   reg [6:0]           ctrl_r;
   reg [`CSLRQ_D_W-1:0] stat_r;
   reg [`CSLRQ_D_W-1:0] mask_r;
   reg [`CSLRQ_D_W-1:0] prev_r;
   reg                 hw_pend_r;
   reg [24:0]          act_r;
   reg                 dir_up_r;
   reg [23:0]          flash_cnt_r;
   reg [1:0]           flash_st_r;
   reg [1:0]           flash_st_nxt;

   wire param_ok = ctrl_r[`CSLRQ_C_PARAM_OK];
   wire low_lat  = ctrl_r[`CSLRQ_C_FAST] | ctrl_r[`CSLRQ_C_MOTION];
   wire new_rev  = ctrl_r[`CSLRQ_C_NEWREV];

   // Lost hardware interrupt: new request while previous unacknowledged
   wire hw_lost = i_hw_irq_req & hw_pend_r & ~i_hw_irq_ack & ~low_lat;

   always @(posedge i_core_clk) begin
      if (i_rst)
         hw_pend_r <= 1'b0;
      else if (i_hw_irq_req)
         hw_pend_r <= 1'b1;
      else if (i_hw_irq_ack)
         hw_pend_r <= 1'b0;
   end

   // Present fault levels
   reg [`CSLRQ_D_W-1:0] cond;
   always @* begin
      cond = `CSLRQ_D_ZERO;
      cond[`CSLRQ_D_PARAM]    = i_param_err;
      cond[`CSLRQ_D_HWLOST]   = hw_lost;
      cond[`CSLRQ_D_UNAVAIL]  = i_unavail;
      cond[`CSLRQ_D_INTERNAL] = i_internal_err;
      cond[`CSLRQ_D_WDOG]     = i_wdog_trip;
      cond[`CSLRQ_D_WIREBRK]  = i_wire_break & ctrl_r[`CSLRQ_C_PUSHPULL];
      cond[`CSLRQ_D_GENERAL]  = i_general_err;
      cond[`CSLRQ_D_LOADMISS] = ~i_load_supply_ok | (new_rev & i_undervoltage);
      cond[`CSLRQ_D_ENCSHORT] = i_enc_supply_fault;
      cond[`CSLRQ_D_OUTFAULT] = i_out_fault;
      cond[`CSLRQ_D_SUPPLY]   = i_undervoltage & ~new_rev;
      cond[`CSLRQ_D_TRACK]    = i_track_phase_short;
      cond[`CSLRQ_D_OVERTEMP] = i_overtemp;
   end

   // Interrupt eligibility by class
   function [`CSLRQ_D_W-1:0] irq_enable;
      input [6:0] c;
      begin
         irq_enable = 13'h001F;
         irq_enable[`CSLRQ_D_WIREBRK] = c[`CSLRQ_C_WB_EN];
         irq_enable[12:6] = {7{c[`CSLRQ_C_ADD_EN]}};
      end
   endfunction

   // Rising edge of each interrupt-enabled condition is one detection event
   wire [`CSLRQ_D_W-1:0] evt = cond & ~prev_r & irq_enable(ctrl_r);
   wire [`CSLRQ_D_W-1:0] w1c = (i_wr && i_addr == `CSLRQ_A_STAT) ?
                               i_wdata[`CSLRQ_D_W-1:0] : `CSLRQ_D_ZERO;

   // Set wins over write-one clear; nothing here halts the block
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         stat_r <= `CSLRQ_D_ZERO;
         prev_r <= `CSLRQ_D_ZERO;
      end else begin
         stat_r <= (stat_r & ~w1c) | evt;
         prev_r <= cond;
      end
   end

   assign o_irq = |(stat_r & mask_r);

   // Control and mask registers
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         ctrl_r <= `CSLRQ_CTRL_RST;
         mask_r <= `CSLRQ_MASK_RST;
      end else if (i_wr) begin
         if (i_addr == `CSLRQ_A_CTRL)
            ctrl_r <= i_wdata[6:0];
         if (i_addr == `CSLRQ_A_MASK)
            mask_r <= i_wdata[`CSLRQ_D_W-1:0];
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge i_core_clk) begin
      if (i_rst)
         o_rdata <= 16'h0000;
      else if (i_rd) begin
         case (i_addr)
            `CSLRQ_A_CTRL: o_rdata <= {9'h000, ctrl_r};
            `CSLRQ_A_STAT: o_rdata <= {3'h0, stat_r};
            `CSLRQ_A_MASK: o_rdata <= {3'h0, mask_r};
            `CSLRQ_A_PEND: o_rdata <= {3'h0, cond};
            default:       o_rdata <= 16'h0000;
         endcase
      end else
         o_rdata <= 16'h0000;
   end

   // Flash timebase for the fault lamp
   always @* begin
      case (flash_st_r)
         FL_OFF:  flash_st_nxt = (flash_cnt_r == 24'h00_0000) ? FL_ON : FL_OFF;
         FL_ON:   flash_st_nxt = (flash_cnt_r == 24'h00_0000) ? FL_OFF : FL_ON;
         default: flash_st_nxt = FL_OFF;
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         flash_st_r  <= FL_OFF;
         flash_cnt_r <= FLASH - 24'h00_0001;
      end else begin
         flash_st_r  <= flash_st_nxt;
         flash_cnt_r <= (flash_cnt_r == 24'h00_0000) ? FLASH - 24'h00_0001 :
                        flash_cnt_r - 24'h00_0001;
      end
   end

   wire flash_on = (flash_st_r == FL_ON);
   // Any pending condition counts as module diagnostics
   wire fault_indicator_lamp_any = |cond;

   // Fault lamp: green steady when all well, red flash on diagnostics
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_fault_lamp_red   <= 1'b0;
         o_fault_lamp_green <= 1'b0;
      end else if (!i_bus_supply_ok) begin
         o_fault_lamp_red   <= 1'b0;
         o_fault_lamp_green <= 1'b0;
      end else if (!param_ok) begin
         o_fault_lamp_red   <= 1'b0;
         o_fault_lamp_green <= flash_on;
      end else if (fault_indicator_lamp_any) begin
         o_fault_lamp_red   <= flash_on;
         o_fault_lamp_green <= 1'b0;
      end else begin
         o_fault_lamp_red   <= 1'b0;
         o_fault_lamp_green <= 1'b1;
      end
   end

   // Supply lamps
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_bus_power_lamp   <= 1'b0;
         o_load_supply_lamp <= 1'b0;
      end else begin
         o_bus_power_lamp   <= i_load_supply_ok;
         o_load_supply_lamp <= i_load_supply_ok & ~i_enc_supply_fault &
                               ~i_undervoltage;
      end
   end

   // Direction lamps with activity timeout
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         act_r    <= 25'h000_0000;
         dir_up_r <= 1'b0;
      end else if (i_count_pulse) begin
         act_r    <= ACT;
         dir_up_r <= i_count_up;
      end else if (act_r != 25'h000_0000)
         act_r <= act_r - 25'h000_0001;
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_count_up_lamp   <= 1'b0;
         o_count_down_lamp <= 1'b0;
      end else begin
         o_count_up_lamp   <= (act_r != 25'h000_0000) & dir_up_r;
         o_count_down_lamp <= (act_r != 25'h000_0000) & ~dir_up_r;
      end
   end

   // Channel lamps, one limiter each
   wire [7:0] ch_sig = {i_out_cmd, i_aux_input_m, i_track_n, i_track_b, i_track_a};
   wire [7:0] ch_lamp;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ch
         cslrq_lamp_lim u_lim (
            .i_core_clk (i_core_clk),
            .i_rst      (i_rst),
            .i_sig      (ch_sig[g]),
            .o_lamp     (ch_lamp[g])
         );
      end
   endgenerate

   assign o_track_a_lamp   = ch_lamp[0];
   assign o_track_b_lamp   = ch_lamp[1];
   assign o_track_n_lamp   = ch_lamp[2];
   assign o_aux_input_lamp = ch_lamp[5:3];
   assign o_out_lamp       = ch_lamp[7:6];
endmodule // cslrq_top

/* File: cslrq_monitor.sv */
// Assertions on the lamp and interrupt ports.
// Bound into every cslrq_top instance at the foot of this file.
`timescale 1ns/1ps
`include "cslrq_map.vh"
module cslrq_monitor (
   input wire i_core_clk,
   input wire i_rst,
   input wire i_bus_supply_ok,
   input wire i_load_supply_ok,
   input wire i_enc_supply_fault,
   input wire i_track_a,
   input wire i_count_pulse,
   input wire i_count_up,
   input wire o_fault_lamp_red,
   input wire o_fault_lamp_green,
   input wire o_bus_power_lamp,
   input wire o_load_supply_lamp,
   input wire o_track_a_lamp,
   input wire o_count_up_lamp,
   input wire o_count_down_lamp,
   input wire o_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Quiet window lets the two-cycle direction path settle
   sequence s_up;
      i_count_pulse && i_count_up ##1 !i_count_pulse [*2];
   endsequence
   sequence s_dn;
      i_count_pulse && !i_count_up ##1 !i_count_pulse [*2];
   endsequence
   // Cycles since the last count pulse, saturating; too long to unroll
   logic [25:0] idle_r;
   always_ff @(posedge i_core_clk) begin
      if (i_rst || i_count_pulse)
         idle_r <= 26'h000_0000;
      else if (idle_r != 26'h3ff_ffff)
         idle_r <= idle_r + 26'h000_0001;
   end
   a_dir_idle: assert property (
      idle_r > `CSLRQ_ACT_CYC |-> !o_count_up_lamp && !o_count_down_lamp)
      else $error("direction lamp lit after idle time");
   a_dir_excl: assert property (
      !(o_count_up_lamp && o_count_down_lamp))
      else $error("both direction lamps lit");
   a_bus_dark: assert property (
      !i_bus_supply_ok |=> !o_fault_lamp_red && !o_fault_lamp_green)
      else $error("fault lamp lit without bus supply");
   a_load_dark: assert property (
      !i_load_supply_ok |=> !o_bus_power_lamp && !o_load_supply_lamp)
      else $error("supply lamps lit without supply");
   a_enc_fault: assert property (
      i_load_supply_ok && i_enc_supply_fault |=> o_bus_power_lamp && !o_load_supply_lamp)
      else $error("supply lamps wrong on encoder fault");
   // Reset clears lamps, so the edge after it is not a real change
   a_lamp_follow: assert property (
      !$past(i_rst) && $changed(o_track_a_lamp) |-> o_track_a_lamp == $past(i_track_a))
      else $error("track lamp moved away from its signal");
   a_lamp_hold: assert property (
      !$past(i_rst) && $changed(o_track_a_lamp) |=> $stable(o_track_a_lamp) [*8])
      else $error("track lamp toggled too fast");
   a_up_dir: assert property (
      s_up |=> o_count_up_lamp && !o_count_down_lamp)
      else $error("up lamp missing after up pulse");
   a_down_dir: assert property (
      s_dn |=> !o_count_up_lamp && o_count_down_lamp)
      else $error("down lamp missing after down pulse");
   a_rst_dark: assert property (
      $fell(i_rst) |-> !o_irq && !o_bus_power_lamp && !o_count_up_lamp && !o_track_a_lamp)
      else $error("outputs not dark after reset");
endmodule // cslrq_monitor

bind cslrq_top cslrq_monitor u_mon (.*);

/* File: cslrq_cpu_model.sv */
// Controller stand-in: acknowledges hardware interrupts late or promptly.
// Assumes request pulses on the core clock.
`timescale 1ns/1ps
module cslrq_cpu_model (
   input  wire       i_core_clk,
   input  wire       i_rst,
   input  wire       i_hw_irq_req,
   input  wire [7:0] i_delay,
   output reg        o_ack
);
   reg [7:0] wait_r;
   // A newer request restarts the wait: one ack serves the latest
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         wait_r <= 8'h00;
         o_ack  <= 1'b0;
      end else if (i_hw_irq_req) begin
         wait_r <= i_delay;
         o_ack  <= 1'b0;
      end else if (wait_r != 8'h00) begin
         wait_r <= wait_r - 8'h01;
         o_ack  <= (wait_r == 8'h01);
      end else begin
         o_ack  <= 1'b0;
      end
   end
endmodule // cslrq_cpu_model

/* File: tb_top.sv */
// Self-checking bench for the lamp and diagnostic-interrupt block.
// Drives inputs at rising edges; a model plays the controller acknowledge.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic        i_core_clk = 0, i_rst = 1, i_bus_supply_ok = 1, i_load_supply_ok = 1;
   logic        i_enc_supply_fault = 0, i_undervoltage = 0, i_track_a = 0, i_track_b = 0;
   logic        i_track_n = 0, i_count_pulse = 0, i_count_up = 0, i_hw_irq_req = 0;
   logic        i_wr = 0, i_rd = 0;
   logic [2:0]  i_aux_input_m = 0;
   logic [1:0]  i_out_cmd = 0;
   logic [8:0]  flt = 0;
   logic [3:0]  i_addr = 0;
   logic [15:0] i_wdata = 0, e;
   logic [7:0]  dly = 1;
   wire  [15:0] o_rdata;
   wire  [2:0]  o_aux_input_lamp;
   wire  [1:0]  o_out_lamp;
   wire         i_hw_irq_ack, o_fault_lamp_red, o_fault_lamp_green, o_bus_power_lamp;
   wire         o_load_supply_lamp, o_track_a_lamp, o_track_b_lamp, o_track_n_lamp;
   wire         o_count_up_lamp, o_count_down_lamp, o_irq;
   wire         i_param_err = flt[0], i_unavail = flt[1], i_internal_err = flt[2];
   wire         i_wdog_trip = flt[3], i_wire_break = flt[4], i_general_err = flt[5];
   wire         i_out_fault = flt[6], i_overtemp = flt[7], i_track_phase_short = flt[8];
   int          checks = 0, n_errors = 0, cyc = 0;
   int          bp[9] = '{0, 2, 3, 4, 5, 6, 9, 12, 11};
   logic [2:0]  sv[4] = '{3'b000, 3'b110, 3'b101, 3'b101};
   logic [15:0] se[4] = '{16'h0080, 16'h0100, 16'h0400, 16'h0080};

   cslrq_top u_dut (.*);
   cslrq_cpu_model u_cpu (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_hw_irq_req(i_hw_irq_req),
                          .i_delay(dly), .o_ack(i_hw_irq_ack));

   initial forever #10 i_core_clk = ~i_core_clk;

   task finish_test;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task look(input int n);
      tick(n);
      @(negedge i_core_clk);
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] x);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      @(negedge i_core_clk);
      `CHK(o_rdata, x)
   endtask
   // Status read, interrupt level, then clear everything
   task ev(input logic [15:0] x, input logic q);
      rd(4'h1, x);
      `CHK(o_irq, q)
      wr(4'h1, 16'h1fff);
   endtask
   task hreq;
      @(posedge i_core_clk);
      i_hw_irq_req <= 1'b1;
      @(posedge i_core_clk);
      i_hw_irq_req <= 1'b0;
   endtask

   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         finish_test;
      end
   end

   initial begin
      tick(12);
      i_rst <= 1'b0;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h3, 16'h0000);
      `CHK({o_fault_lamp_red, o_fault_lamp_green}, 2'b00)
      wr(4'h9, 16'hffff);
      rd(4'h9, 16'h0000);
      wr(4'h2, 16'h1fff);
      rd(4'h2, 16'h1fff);
      for (int m = 0; m < 3; m++) begin
         wr(4'h0, m == 0 ? 16'h000f : m == 1 ? 16'h0001 : 16'h000b);
         for (int k = 0; k < 9; k++) begin
            e = (m == 0 || k < 4 || (m == 2 && k > 4)) ? 16'h0001 << bp[k] : 16'h0000;
            flt[k] <= 1'b1;
            look(2);
            ev(e, |e);
            flt[k] <= 1'b0;
         end
      end
      look(2);
      `CHK({o_fault_lamp_red, o_fault_lamp_green}, 2'b01)
      tick(1);
      flt[2] <= 1'b1;
      look(2);
      `CHK(o_fault_lamp_green, 1'b0)
      rd(4'h3, 16'h0008);
      tick(1);
      flt[2] <= 1'b0;
      wr(4'h1, 16'h1fff);
      look(2);
      `CHK({o_fault_lamp_red, o_fault_lamp_green}, 2'b01)
      tick(1);
      i_bus_supply_ok <= 1'b0;
      look(2);
      `CHK({o_fault_lamp_red, o_fault_lamp_green}, 2'b00)
      tick(1);
      i_bus_supply_ok <= 1'b1;
      wr(4'h2, 16'h0000);
      flt[0] <= 1'b1;
      look(2);
      ev(16'h0001, 1'b0);
      flt[0] <= 1'b0;
      for (int j = 0; j < 4; j++) begin
         wr(4'h0, j == 0 ? 16'h0011 : j == 1 ? 16'h0021 : 16'h0001);
         dly <= j == 3 ? 8'h01 : 8'h1e;
         tick(40);
         hreq;
         if (j == 3) tick(4);
         hreq;
         look(2);
         ev(j == 2 ? 16'h0002 : 16'h0000, 1'b0);
      end
      wr(4'h0, 16'h0009);
      for (int j = 0; j < 4; j++) begin
         if (j == 3) wr(4'h0, 16'h0049);
         {i_load_supply_ok, i_enc_supply_fault, i_undervoltage} <= sv[j];
         look(2);
         `CHK({o_bus_power_lamp, o_load_supply_lamp}, j ? 2'b10 : 2'b00)
         ev(se[j], 1'b0);
         {i_load_supply_ok, i_enc_supply_fault, i_undervoltage} <= 3'b100;
         tick(1);
      end
      {i_track_a, i_track_b, i_track_n, i_aux_input_m, i_out_cmd} <= 8'hf6;
      look(2);
      `CHK({o_track_a_lamp, o_track_b_lamp, o_track_n_lamp, o_aux_input_lamp, o_out_lamp}, 8'hf6)
      tick(1);
      {i_track_a, i_track_b, i_track_n, i_aux_input_m, i_out_cmd} <= 8'h00;
      look(3);
      `CHK({o_track_a_lamp, o_track_b_lamp, o_track_n_lamp, o_aux_input_lamp, o_out_lamp}, 8'hf6)
      for (int j = 0; j < 2; j++) begin
         tick(1);
         i_count_pulse <= 1'b1;
         i_count_up <= (j == 0);
         tick(1);
         i_count_pulse <= 1'b0;
         look(4);
         `CHK({o_count_up_lamp, o_count_down_lamp}, j ? 2'b01 : 2'b10)
      end
      finish_test;
   end
endmodule // tb_top
